// *** rtl/ref_event_path.sv ***
/*
  Reference event path: polarity correction, receiver gating and
  event detection on the alignment reference.
  Assumes refRaw is already synchronous to clock.
*/
`timescale 1ns/1ns
`default_nettype none

module ref_event_path
  import sysref_clock_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic refRaw,
  input wire ref_ctrl_t ctrl,
  output logic refEvent
);

  logic levelFf;
  logic eventFf;
  logic nxt_level;
  logic nxt_event;

  always_comb begin
    // Receiver off holds the level low, so an input already high gives an edge on enable
    nxt_level = ctrl.receiverOn ? (refRaw ^ ctrl.polarityFlip) : 1'b0;
    nxt_event = ctrl.processorOn & nxt_level & ~levelFf;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      levelFf <= 1'b0;
      eventFf <= 1'b0;
    end else begin
      levelFf <= nxt_level;
      eventFf <= nxt_event;
    end
  end

  assign refEvent = eventFf;

endmodule

`default_nettype wire

// *** rtl/sysref_clock_consts.svh ***
/*
  Constants for the reference-clock control bank: register addresses,
  reset values and field positions.
  Assumes a 15-bit register address and 8-bit register data.
*/
`ifndef SYSREF_CLOCK_CONSTS_SVH
`define SYSREF_CLOCK_CONSTS_SVH

`define REF_CLOCK_CONTROL_ADDR 15'h0029
`define CLOCK_INPUT_OPTIONS_ADDR 15'h002A
`define SUPPLY_NOISE_CONTROL_ADDR 15'h002B
`define REF_EDGE_POSITION_ADDR 15'h002C
`define REF_EDGE_POSITION_ADDR1 15'h002D
`define REF_EDGE_POSITION_ADDR2 15'h002E

`define REF_CLOCK_CONTROL_RST 8'h80
`define CLOCK_INPUT_OPTIONS_RST 8'h00
`define SUPPLY_NOISE_CONTROL_RST 8'h10

`define REF_PROCESSOR_ON_BIT 6
`define REF_RECEIVER_ON_BIT 5
`define WINDOW_FINE_STEPS_BIT 4
`define REF_DELAY_CHOICE_MSB 3
`define REF_DELAY_CHOICE_LSB 0
`define MAIN_CLOCK_PECL_MODE_BIT 2
`define REF_INPUT_PECL_MODE_BIT 1
`define REF_POLARITY_FLIP_BIT 0
`define QUANTIZER_SUPPLY_QUIET_BIT 2
`define CLOCK_SUPPLY_QUIET_BIT 0

`define REG_DATA_W 8
`define REG_ADDR_W 15
`define POS_MAX_W 24

`endif

// *** rtl/sysref_clock_control_regs.sv ***
/*
  Reference-clock control register bank: three 8-bit control registers,
  the read-only edge position status and the reference event path.
  Assumes an upstream serial decoder presents one access per cycle on
  regReq and that softReset is a synchronous one-cycle pulse.
*/
// Behaviour
// - Three registers at 0x29, 0x2A, 0x2B reset to 0x80, 0x00, 0x10.
// - Bit 6 of 0x29 enables reference processing; cleared, events are ignored.
// - Bit 5 of 0x29 enables the reference receiver; cleared, it stays off.
// - Bit 4 of 0x29 selects finer windowing delay steps.
// - Bits 3:0 of 0x29 choose the applied reference delay.
// - Bit 2 of 0x2A sets main clock PECL mode, disabling its self-bias.
// - Bit 1 of 0x2A sets reference PECL mode, removing its self-bias.
// - Bit 0 of 0x2A inverts the reference before alignment logic.
// - Bits 2 and 0 of 0x2B quiet quantizer and clock supplies.
// - Soft reset returns all three registers to reset values.
// - A read-only 24-bit edge position status is readable.
`timescale 1ns/1ns
`default_nettype none
`include "sysref_clock_consts.svh"

module sysref_clock_control_regs
  import sysref_clock_pkg::*;
#(
  parameter int POS_W = 24
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic softReset,
  input wire reg_req_t regReq,
  output logic [`REG_DATA_W-1:0] regRdata,
  input wire logic [POS_W-1:0] refEdgePosition,
  input wire logic refRaw,
  output logic refEvent,
  output logic refProcessorOn,
  output logic refReceiverOn,
  output logic windowFineSteps,
  output logic [3:0] refDelayChoice,
  output logic mainClockPeclMode,
  output logic mainClockSelfBiasOn,
  output logic refInputPeclMode,
  output logic refSelfBiasOn,
  output logic refPolarityFlip,
  output logic quantizerSupplyQuiet,
  output logic clockSupplyQuiet
);

  if (POS_W < 1 || POS_W > `POS_MAX_W) begin : gBadPos
    $error("POS_W must lie between 1 and 24");
  end

  ////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0] ctrl0Ff;
  logic [7:0] ctrl1Ff;
  logic [7:0] ctrl2Ff;
  logic [1:0] biasFf;
  logic [7:0] rdataFf;
  logic [`POS_MAX_W-1:0] posFf;
  logic [7:0] nxt_ctrl0;
  logic [7:0] nxt_ctrl1;
  logic [7:0] nxt_ctrl2;
  logic [1:0] nxt_bias;
  logic [7:0] nxt_rdata;
  logic [`POS_MAX_W-1:0] nxt_pos;

  always_comb begin
    nxt_ctrl0 = ctrl0Ff;
    nxt_ctrl1 = ctrl1Ff;
    nxt_ctrl2 = ctrl2Ff;
    // Reserved bits are stored as written; keeping them is the host's job
    if (softReset) begin
      nxt_ctrl0 = `REF_CLOCK_CONTROL_RST;
      nxt_ctrl1 = `CLOCK_INPUT_OPTIONS_RST;
      nxt_ctrl2 = `SUPPLY_NOISE_CONTROL_RST;
    end else if (regReq.write) begin
      unique case (regReq.addr)
        `REF_CLOCK_CONTROL_ADDR: nxt_ctrl0 = regReq.wdata;
        `CLOCK_INPUT_OPTIONS_ADDR: nxt_ctrl1 = regReq.wdata;
        `SUPPLY_NOISE_CONTROL_ADDR: nxt_ctrl2 = regReq.wdata;
        default: ;
      endcase
    end
    // Self-bias follows the PECL bits in the same edge, never a cycle late
    nxt_bias[1] = ~nxt_ctrl1[`MAIN_CLOCK_PECL_MODE_BIT];
    nxt_bias[0] = ~nxt_ctrl1[`REF_INPUT_PECL_MODE_BIT];
    nxt_pos = '0;
    nxt_pos[POS_W-1:0] = refEdgePosition;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path; reads see the value before a write in the same cycle

  always_comb begin
    nxt_rdata = 8'h00;
    if (regReq.read) begin
      unique case (regReq.addr)
        `REF_CLOCK_CONTROL_ADDR: nxt_rdata = ctrl0Ff;
        `CLOCK_INPUT_OPTIONS_ADDR: nxt_rdata = ctrl1Ff;
        `SUPPLY_NOISE_CONTROL_ADDR: nxt_rdata = ctrl2Ff;
        `REF_EDGE_POSITION_ADDR: nxt_rdata = posFf[7:0];
        `REF_EDGE_POSITION_ADDR1: nxt_rdata = posFf[15:8];
        `REF_EDGE_POSITION_ADDR2: nxt_rdata = posFf[23:16];
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0Ff <= `REF_CLOCK_CONTROL_RST;
      ctrl1Ff <= `CLOCK_INPUT_OPTIONS_RST;
      ctrl2Ff <= `SUPPLY_NOISE_CONTROL_RST;
      biasFf <= 2'h3;
      rdataFf <= 8'h00;
      posFf <= '0;
    end else begin
      ctrl0Ff <= nxt_ctrl0;
      ctrl1Ff <= nxt_ctrl1;
      ctrl2Ff <= nxt_ctrl2;
      biasFf <= nxt_bias;
      rdataFf <= nxt_rdata;
      posFf <= nxt_pos;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field outputs, each a flip-flop bit

  assign regRdata = rdataFf;
  assign refProcessorOn = ctrl0Ff[`REF_PROCESSOR_ON_BIT];
  assign refReceiverOn = ctrl0Ff[`REF_RECEIVER_ON_BIT];
  assign windowFineSteps = ctrl0Ff[`WINDOW_FINE_STEPS_BIT];
  assign refDelayChoice = ctrl0Ff[`REF_DELAY_CHOICE_MSB:`REF_DELAY_CHOICE_LSB];
  assign mainClockPeclMode = ctrl1Ff[`MAIN_CLOCK_PECL_MODE_BIT];
  assign refInputPeclMode = ctrl1Ff[`REF_INPUT_PECL_MODE_BIT];
  assign refPolarityFlip = ctrl1Ff[`REF_POLARITY_FLIP_BIT];
  assign mainClockSelfBiasOn = biasFf[1];
  assign refSelfBiasOn = biasFf[0];
  assign quantizerSupplyQuiet = ctrl2Ff[`QUANTIZER_SUPPLY_QUIET_BIT];
  assign clockSupplyQuiet = ctrl2Ff[`CLOCK_SUPPLY_QUIET_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Reference event path

  ref_ctrl_t refCtrl;

  // Processor enable without the receiver yields nothing; host orders them
  always_comb begin
    refCtrl.receiverOn = refReceiverOn;
    refCtrl.processorOn = refProcessorOn;
    refCtrl.polarityFlip = refPolarityFlip;
  end

  ref_event_path uEventPath (
    .clock(clock),
    .rst_n(rst_n),
    .refRaw(refRaw),
    .ctrl(refCtrl),
    .refEvent(refEvent)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks

  logic wrCtrl0;
  logic wrCtrl1;
  logic wrCtrl2;
  assign wrCtrl0 = regReq.write && !softReset && regReq.addr == `REF_CLOCK_CONTROL_ADDR;
  assign wrCtrl1 = regReq.write && !softReset && regReq.addr == `CLOCK_INPUT_OPTIONS_ADDR;
  assign wrCtrl2 = regReq.write && !softReset && regReq.addr == `SUPPLY_NOISE_CONTROL_ADDR;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_SOFT_RESET: assert property (softReset |=>
    ctrl0Ff == 8'h80 && ctrl1Ff == 8'h00 && ctrl2Ff == 8'h10)
    else $error("soft reset did not restore control registers");
  // Write, one idle cycle, then the read; the gap keeps soft reset out of the way
  AST_WRITE_READBACK: assert property (wrCtrl1 ##1 (!regReq.write && !softReset)
    ##1 (regReq.read && regReq.addr == `CLOCK_INPUT_OPTIONS_ADDR)
    |=> regRdata == $past(regReq.wdata, 3))
    else $error("clock input options read back wrong");
  AST_RDATA_IDLE: assert property (!regReq.read |=> regRdata == 8'h00)
    else $error("read data not cleared without a read");
  AST_PROC_GATE: assert property (refEvent |-> $past(refProcessorOn))
    else $error("reference event while processor disabled");
  AST_RECV_OFF: assert property (!refReceiverOn [*2] |=> !refEvent)
    else $error("reference event while receiver disabled");
  AST_ZOOM_DELAY: assert property (wrCtrl0 |=>
    windowFineSteps == $past(regReq.wdata[4]) && refDelayChoice == $past(regReq.wdata[3:0]))
    else $error("delay fields do not follow write");
  AST_MAIN_BIAS: assert property (mainClockPeclMode |-> !mainClockSelfBiasOn)
    else $error("main clock self-bias on in PECL mode");
  AST_REF_BIAS: assert property (refSelfBiasOn == !refInputPeclMode)
    else $error("reference self-bias disagrees with PECL mode");
  AST_POLARITY: assert property (refEvent |-> $past(refRaw) != $past(refPolarityFlip))
    else $error("reference event ignores polarity flip");
  AST_SUPPLY: assert property (wrCtrl2 |=> quantizerSupplyQuiet == $past(regReq.wdata[2])
    && clockSupplyQuiet == $past(regReq.wdata[0]))
    else $error("supply quiet bits do not follow write");
  AST_POS_READ: assert property (regReq.read && regReq.addr == `REF_EDGE_POSITION_ADDR
    |=> regRdata == $past(posFf[7:0]))
    else $error("edge position low byte read wrong");
  AST_RESET_VALUE: assert property ($rose(rst_n) |-> ctrl0Ff == 8'h80)
    else $error("clock control reset value wrong");

  COV_EVENT: cover property (refReceiverOn && refProcessorOn ##1 refEvent);
  COV_FLIPPED: cover property (refPolarityFlip && refEvent);
  COV_SOFT_AFTER_WRITE: cover property (wrCtrl0 ##1 softReset);
  COV_POS_READ: cover property (regReq.read && regReq.addr == `REF_EDGE_POSITION_ADDR2);
  COV_READBACK: cover property (wrCtrl1 ##2 (regReq.read && regReq.addr == 15'h002A));

endmodule

`default_nettype wire

// *** rtl/sysref_clock_pkg.sv ***
/*
  Types shared by the reference-clock control bank and its event path.
  Assumes the constants header is on the include path.
*/
`include "sysref_clock_consts.svh"

package sysref_clock_pkg;

  // One register access from the serial interface decoder
  typedef struct packed {
    logic write;
    logic read;
    logic [`REG_ADDR_W-1:0] addr;
    logic [`REG_DATA_W-1:0] wdata;
  } reg_req_t;

  // Controls handed to the reference event path
  typedef struct packed {
    logic receiverOn;
    logic processorOn;
    logic polarityFlip;
  } ref_ctrl_t;

endpackage

// *** testbench/reg_host_model.sv ***
/* Host model issuing single register writes and reads on the request port.
   Assumes read data is registered and valid one cycle after the request. */
`timescale 1ns/1ns
`default_nettype none
module reg_host_model
  import sysref_clock_pkg::*;
(
  input wire logic clock,
  input wire logic [7:0] regRdata,
  output var reg_req_t regReq
);
  initial regReq = '0;
  // Released address and data flip so stale values never look valid
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge clock);
    regReq <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    regReq <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [14:0] a, output logic [7:0] d);
    @(posedge clock);
    regReq <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    regReq <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: 8'hFF};
    @(negedge clock);
    d = regRdata;
  endtask
endmodule
`default_nettype wire

// *** testbench/sysref_clock_control_regs_tb.sv ***
/* Self-checking bench for the reference-clock control bank.
   Assumes the host model drives the request port and the bank's defaults. */
`timescale 1ns/1ns
`default_nettype none
`include "sysref_clock_consts.svh"
module sysref_clock_control_regs_tb;
  import sysref_clock_pkg::*;
  logic clock, rst_n, softReset, refRaw, refEvent;
  logic [23:0] refEdgePosition;
  reg_req_t regReq;
  logic [7:0] regRdata, rdv, ctl0, ctl1;
  logic [3:0] refDelayChoice;
  logic refProcessorOn, refReceiverOn, windowFineSteps, mainClockPeclMode;
  logic mainClockSelfBiasOn, refInputPeclMode, refSelfBiasOn, refPolarityFlip;
  logic quantizerSupplyQuiet, clockSupplyQuiet;
  int errCount = 0, numChecks = 0, cycles = 0, events = 0;
  assign ctl0 = {1'b0, refProcessorOn, refReceiverOn, windowFineSteps, refDelayChoice};
  assign ctl1 = {1'b0, mainClockSelfBiasOn, refSelfBiasOn, quantizerSupplyQuiet,
    clockSupplyQuiet, mainClockPeclMode, refInputPeclMode, refPolarityFlip};
  sysref_clock_control_regs #(.POS_W(24)) dut (.clock(clock), .rst_n(rst_n),
    .softReset(softReset), .regReq(regReq), .regRdata(regRdata),
    .refEdgePosition(refEdgePosition), .refRaw(refRaw), .refEvent(refEvent),
    .refProcessorOn(refProcessorOn), .refReceiverOn(refReceiverOn),
    .windowFineSteps(windowFineSteps), .refDelayChoice(refDelayChoice),
    .mainClockPeclMode(mainClockPeclMode), .mainClockSelfBiasOn(mainClockSelfBiasOn),
    .refInputPeclMode(refInputPeclMode), .refSelfBiasOn(refSelfBiasOn),
    .refPolarityFlip(refPolarityFlip), .quantizerSupplyQuiet(quantizerSupplyQuiet),
    .clockSupplyQuiet(clockSupplyQuiet));
  reg_host_model host (.clock(clock), .regRdata(regRdata), .regReq(regReq));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (refEvent === 1'b1) events++;
    if (cycles == 5000) begin
      errCount++;
      printVerdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    numChecks++;
    if (g !== e) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(input logic [14:0] a, input logic [7:0] e);
    host.rd(a, rdv);
    chk($sformatf("read %h", a), e, rdv);
  endtask
  // Events are counted over a window, so latency slips still show as counts
  task automatic pulse(input logic v, input logic [7:0] e);
    events = 0;
    @(posedge clock) refRaw <= v;
    repeat (5) @(posedge clock);
    chk("event count", e, events[7:0]);
  endtask
  task automatic printVerdict();
    if (errCount == 0 && numChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk(`REF_CLOCK_CONTROL_ADDR, 8'h80);
    rdchk(`CLOCK_INPUT_OPTIONS_ADDR, 8'h00);
    rdchk(`SUPPLY_NOISE_CONTROL_ADDR, 8'h10);
    chk("ctl0", 8'h00, ctl0);
    chk("ctl1", 8'h60, ctl1);
  endtask
  task automatic t_fields();
    host.wr(`REF_CLOCK_CONTROL_ADDR, 8'hA0);
    @(negedge clock);
    chk("ctl0", 8'h20, ctl0);
    host.wr(`REF_CLOCK_CONTROL_ADDR, 8'hF5);
    @(negedge clock);
    chk("ctl0", 8'h75, ctl0);
    rdchk(`REF_CLOCK_CONTROL_ADDR, 8'hF5);
    host.wr(`CLOCK_INPUT_OPTIONS_ADDR, 8'h07);
    host.wr(`SUPPLY_NOISE_CONTROL_ADDR, 8'h15);
    @(negedge clock);
    chk("ctl1", 8'h1F, ctl1);
    rdchk(`CLOCK_INPUT_OPTIONS_ADDR, 8'h07);
    rdchk(`SUPPLY_NOISE_CONTROL_ADDR, 8'h15);
  endtask
  task automatic t_event();
    pulse(1'b1, 8'h00);
    pulse(1'b0, 8'h01);
    host.wr(`CLOCK_INPUT_OPTIONS_ADDR, 8'h00);
    pulse(1'b1, 8'h01);
    pulse(1'b0, 8'h00);
    host.wr(`REF_CLOCK_CONTROL_ADDR, 8'hA5);
    pulse(1'b1, 8'h00);
  endtask
  task automatic t_soft();
    // Non-reset value in clock input options; the other two registers already differ from reset, so the soft reset has work to do
    host.wr(`CLOCK_INPUT_OPTIONS_ADDR, 8'h07);
    rdchk(`CLOCK_INPUT_OPTIONS_ADDR, 8'h07);
    @(posedge clock) softReset <= 1'b1;
    @(posedge clock) softReset <= 1'b0;
    rdchk(`REF_CLOCK_CONTROL_ADDR, 8'h80);
    rdchk(`CLOCK_INPUT_OPTIONS_ADDR, 8'h00);
    rdchk(`SUPPLY_NOISE_CONTROL_ADDR, 8'h10);
    chk("ctl0", 8'h00, ctl0);
    chk("ctl1", 8'h60, ctl1);
  endtask
  task automatic t_pos();
    rdchk(`REF_EDGE_POSITION_ADDR, 8'h81);
    rdchk(`REF_EDGE_POSITION_ADDR1, 8'h3C);
    rdchk(`REF_EDGE_POSITION_ADDR2, 8'h5A);
    rdchk(15'h0030, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    softReset = 1'b0;
    refRaw = 1'b0;
    refEdgePosition = 24'h5A3C81;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_fields();
    t_event();
    t_soft();
    t_pos();
    printVerdict();
  end
endmodule
`default_nettype wire
